/* File: src/crp_pin_ctrl.sv */
// pin-level clock, reset and operating-state control of the processor
// assumes the core, bus unit and power logic drive the request inputs synchronously
// Behaviour
// - the output clock is half the input clock, 50% duty, toggling on each falling edge.
// - the crystal drive pin keeps driving in the all-pins-float test mode.
// - reset aborts any bus cycle one clock after the synchronised reset input, initializes the block and defines every pin.
// - the reset indication stays asserted as long as the reset input is asserted.
// - on reset release the output clock is first aligned, then fetch starts at 0ffff0h.
// - the reset indication is low in bus hold, high in reset and low in powerdown.
// - the test/busy pin is sampled in reset to pick coprocessor mode.
// - in regular mode the wait instruction stalls the cpu until test reads low.
// - the non-maskable interrupt is edge sensitive, latched, and asks for type 2.
// - the address/data pins carry the address in the address phase and data after.
// - the address/data pins float in hold and reset and keep their state in powerdown.
// - after leaving powerdown the block waits on the timer pin before resuming.
// - every output has a defined level in hold, reset, idle and powerdown.
`timescale 1ns/1ps
`include "crp_regs.svh"
module crp_pin_ctrl #(
	parameter int PD_EXIT_MIN_CYC = `CRP_PD_EXIT_MIN_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic reset_input_n,
	input wire logic nmi_pin,
	input wire logic test_busy_pin,
	input wire logic float_strap_ucs_n,
	input wire logic float_strap_lcs_n,
	input wire logic hold_ack,
	input wire logic idle_req,
	input wire logic powerdown_req,
	input wire logic wake_event,
	input wire logic wait_exec,
	input wire logic nmi_ack,
	input wire crp_pkg::crp_core_bus_s core_bus,
	input wire logic powerdown_exit_timer_pin_in,
	output logic half_rate_clock_out,
	output logic crystal_drive_out,
	output logic crystal_drive_oe,
	output logic reset_indication_out,
	output crp_pkg::crp_ad_pin_s muxed_addr_data_bus,
	output logic powerdown_exit_timer_pin_out,
	output logic powerdown_exit_timer_pin_oe,
	output logic all_pins_float_test_mode,
	output logic coproc_mode,
	output logic coproc_busy,
	output logic cpu_stall,
	output logic cpu_run,
	output logic bus_abort,
	output logic fetch_start,
	output logic [19:0] fetch_addr,
	output logic nmi_pending,
	output logic [7:0] nmi_type
);
	// ****************************************
	// input synchronisers and divider
	// ****************************************
	logic [`CRP_SYNC_W-1:0] pins_sync;
	logic rst_in_s;
	logic nmi_s;
	logic test_s;
	logic float_s;
	logic nmi_prev;
	logic align_hold;

	crp_sync #(.W(`CRP_SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in({reset_input_n, nmi_pin, test_busy_pin,
			~float_strap_ucs_n & ~float_strap_lcs_n}),
		.sync_out(pins_sync)
	);
	// reset release is only seen after two clocks of synchronising
	// pin goes in uninverted so the cleared chain reads as reset held, no false release
	assign rst_in_s = !pins_sync[3];
	assign nmi_s = pins_sync[2];
	assign test_s = pins_sync[1];
	assign float_s = pins_sync[0];

	crp_clk_div u_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.align_hold(align_hold),
		.half_rate_clock_out(half_rate_clock_out)
	);

	// ****************************************
	// operating state
	// ****************************************
	crp_pkg::crp_state_e state;
	crp_pkg::crp_state_e next_state;
	logic [`CRP_PD_CNT_W-1:0] pd_cnt;
	logic [`CRP_PD_CNT_W-1:0] next_pd_cnt;
	logic pd_done;

	assign pd_done = (pd_cnt >= PD_EXIT_MIN_CYC[`CRP_PD_CNT_W-1:0]) && !powerdown_exit_timer_pin_in;

	// reset wins over every other state; powerdown exit waits on count and pin
	always_comb begin
		next_state = state;
		next_pd_cnt = '0;
		if (rst_in_s) begin
			next_state = crp_pkg::ST_RESET;
		end else begin
			unique case (state)
				crp_pkg::ST_RESET: begin
					next_state = crp_pkg::ST_ALIGN;
				end
				crp_pkg::ST_ALIGN: begin
					next_state = crp_pkg::ST_RUN;
				end
				crp_pkg::ST_RUN: begin
					if (powerdown_req) begin
						next_state = crp_pkg::ST_PDOWN;
					end else if (hold_ack) begin
						next_state = crp_pkg::ST_HOLD;
					end else if (idle_req) begin
						next_state = crp_pkg::ST_IDLE;
					end
				end
				crp_pkg::ST_HOLD: begin
					if (!hold_ack) begin
						next_state = crp_pkg::ST_RUN;
					end
				end
				crp_pkg::ST_IDLE: begin
					if (wake_event || nmi_s) begin
						next_state = crp_pkg::ST_RUN;
					end
				end
				crp_pkg::ST_PDOWN: begin
					if (wake_event || nmi_s) begin
						next_state = crp_pkg::ST_PDEXIT;
					end
				end
				crp_pkg::ST_PDEXIT: begin
					// the crystal needs time to start; the minimum count and the timer pin set how long
					if (pd_done) begin
						next_state = crp_pkg::ST_RUN;
					end else if (pd_cnt != '1) begin
						next_pd_cnt = pd_cnt + 1'b1;
					end else begin
						next_pd_cnt = pd_cnt;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= crp_pkg::ST_RESET;
			pd_cnt <= '0;
		end else begin
			state <= next_state;
			pd_cnt <= next_pd_cnt;
		end
	end

	// ****************************************
	// straps, modes and core-facing controls
	// ****************************************
	logic next_coproc_mode;
	logic next_float;
	logic next_stall;
	logic next_busy;
	logic next_run;
	logic next_fetch;

	// straps are caught while reset is held and frozen at its release
	always_comb begin
		next_coproc_mode = coproc_mode;
		next_float = all_pins_float_test_mode;
		if (next_state == crp_pkg::ST_RESET) begin
			next_coproc_mode = test_s;
			next_float = float_s;
		end
		next_stall = !coproc_mode && wait_exec && test_s && next_state == crp_pkg::ST_RUN;
		next_busy = coproc_mode && test_s;
		next_run = next_state == crp_pkg::ST_RUN;
		next_fetch = state == crp_pkg::ST_ALIGN && next_state == crp_pkg::ST_RUN;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			coproc_mode <= 1'b0;
			all_pins_float_test_mode <= 1'b0;
			cpu_stall <= 1'b0;
			coproc_busy <= 1'b0;
			cpu_run <= 1'b0;
			fetch_start <= 1'b0;
			fetch_addr <= `CRP_FETCH_ADDR;
			align_hold <= 1'b1;
			bus_abort <= 1'b1;
		end else begin
			coproc_mode <= next_coproc_mode;
			all_pins_float_test_mode <= next_float;
			cpu_stall <= next_stall;
			coproc_busy <= next_busy;
			cpu_run <= next_run;
			fetch_start <= next_fetch;
			fetch_addr <= `CRP_FETCH_ADDR;
			align_hold <= next_state == crp_pkg::ST_RESET;
			bus_abort <= next_state == crp_pkg::ST_RESET;
		end
	end

	// ****************************************
	// non-maskable interrupt latch
	// ****************************************
	logic next_nmi_pending;
	logic nmi_rise;

	assign nmi_rise = nmi_s && !nmi_prev;

	// a new edge in the same cycle as the acknowledge is kept
	always_comb begin
		next_nmi_pending = nmi_pending;
		if (nmi_ack) begin
			next_nmi_pending = 1'b0;
		end
		if (nmi_rise) begin
			next_nmi_pending = 1'b1;
		end
		if (next_state == crp_pkg::ST_RESET) begin
			next_nmi_pending = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			nmi_prev <= 1'b0;
			nmi_pending <= 1'b0;
			nmi_type <= `CRP_NMI_TYPE;
		end else begin
			nmi_prev <= nmi_s;
			nmi_pending <= next_nmi_pending;
			nmi_type <= `CRP_NMI_TYPE;
		end
	end

	// ****************************************
	// pin states per operating state
	// ****************************************
	crp_pkg::crp_ad_pin_s next_ad;
	logic next_reset_indication_out;
	logic next_tmr_out;
	logic next_tmr_oe;

	// powerdown keeps the last bus value; hold, reset and test mode float it
	always_comb begin
		next_ad = muxed_addr_data_bus;
		next_reset_indication_out = next_state == crp_pkg::ST_RESET;
		next_tmr_out = 1'b0;
		next_tmr_oe = 1'b0;
		unique case (next_state)
			crp_pkg::ST_RESET, crp_pkg::ST_HOLD, crp_pkg::ST_ALIGN: begin
				next_ad.oe = 1'b0;
			end
			crp_pkg::ST_PDOWN: begin
				next_tmr_out = 1'b1;
				next_tmr_oe = 1'b1;
			end
			crp_pkg::ST_RUN, crp_pkg::ST_IDLE, crp_pkg::ST_PDEXIT: begin
				if (core_bus.addr_phase) begin
					next_ad.out = core_bus.addr;
					next_ad.oe = 1'b1;
				end else if (core_bus.data_write) begin
					next_ad.out = core_bus.data;
					next_ad.oe = 1'b1;
				end else begin
					next_ad.oe = 1'b0;
				end
			end
		endcase
		if (next_float) begin
			next_ad.oe = 1'b0;
			next_tmr_oe = 1'b0;
		end
	end

	// the crystal drive never floats, even in the float test mode
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			muxed_addr_data_bus <= '0;
			reset_indication_out <= 1'b1;
			powerdown_exit_timer_pin_out <= 1'b0;
			powerdown_exit_timer_pin_oe <= 1'b0;
			crystal_drive_out <= 1'b0;
			crystal_drive_oe <= 1'b1;
		end else begin
			muxed_addr_data_bus <= next_ad;
			reset_indication_out <= next_reset_indication_out;
			powerdown_exit_timer_pin_out <= next_tmr_out;
			powerdown_exit_timer_pin_oe <= next_tmr_oe;
			crystal_drive_out <= ~crystal_drive_out;
			crystal_drive_oe <= 1'b1;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_release;
		state == crp_pkg::ST_RESET && !rst_in_s;
	endsequence
	sequence s_align_then_fetch;
		state == crp_pkg::ST_ALIGN ##1 fetch_start && fetch_addr == `CRP_FETCH_ADDR;
	endsequence

	property p_xtal_drives;
		crystal_drive_oe;
	endproperty
	a_xtal_drives: assert property (p_xtal_drives) else $error("crystal drive released");

	property p_reset_abort;
		rst_in_s |=> bus_abort && !muxed_addr_data_bus.oe && !cpu_run;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

	property p_reset_indication_out_held;
		rst_in_s |=> reset_indication_out;
	endproperty
	a_reset_indication_out_held: assert property (p_reset_indication_out_held) else $error("reset out dropped");

	property p_release_seq;
		s_release |=> s_align_then_fetch;
	endproperty
	a_release_seq: assert property (p_release_seq) else $error("bad release sequence");

	property p_reset_indication_out_low;
		(state == crp_pkg::ST_HOLD || state == crp_pkg::ST_PDOWN) |-> !reset_indication_out;
	endproperty
	a_reset_indication_out_low: assert property (p_reset_indication_out_low) else $error("reset out high in hold");

	property p_strap;
		(state == crp_pkg::ST_RUN) |-> $stable(coproc_mode);
	endproperty
	a_strap: assert property (p_strap) else $error("mode strap changed in run");

	property p_wait_stall;
		(!coproc_mode && wait_exec && test_s && next_state == crp_pkg::ST_RUN) |=> cpu_stall;
	endproperty
	a_wait_stall: assert property (p_wait_stall) else $error("wait did not stall");

	property p_nmi_latch;
		(nmi_rise && next_state != crp_pkg::ST_RESET) |=> nmi_pending && nmi_type == 8'h02;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge lost");

	property p_pd_retain;
		(state == crp_pkg::ST_PDOWN && $past(state) == crp_pkg::ST_PDOWN)
			|-> $stable(muxed_addr_data_bus);
	endproperty
	a_pd_retain: assert property (p_pd_retain) else $error("bus moved in powerdown");

	property p_pd_wait;
		(state == crp_pkg::ST_PDEXIT && !pd_done && !rst_in_s) |=> state == crp_pkg::ST_PDEXIT;
	endproperty
	a_pd_wait: assert property (p_pd_wait) else $error("powerdown exit too early");
endmodule

/* File: common/crp_regs.svh */
// constants for the clock, reset and pin-state control block
// assumes a 100 MHz clk_sys that stands in for the doubled input clock
`ifndef CRP_REGS_SVH
`define CRP_REGS_SVH

// ****************************************
// timing
// ****************************************
`define CRP_CLK_PERIOD_NS 10
`define CRP_PD_EXIT_MIN_NS 1000
// least time, so round up to whole cycles
`define CRP_PD_EXIT_MIN_CYC ((`CRP_PD_EXIT_MIN_NS + `CRP_CLK_PERIOD_NS - 1) / `CRP_CLK_PERIOD_NS)
`define CRP_PD_CNT_W 12

// ****************************************
// fixed values
// ****************************************
`define CRP_FETCH_ADDR 20'hffff0
`define CRP_NMI_TYPE 8'h02
`define CRP_AD_W 16
`define CRP_SYNC_W 4

`endif

/* File: common/crp_pkg.sv */
// types shared by the clock, reset and pin-state control block
// assumes crp_regs.svh is on the include path
package crp_pkg;
	`include "crp_regs.svh"

	// ****************************************
	// operating states, one-hot
	// ****************************************
	typedef enum logic [6:0] {
		ST_RESET = 7'b0000001,
		ST_ALIGN = 7'b0000010,
		ST_RUN = 7'b0000100,
		ST_HOLD = 7'b0001000,
		ST_IDLE = 7'b0010000,
		ST_PDOWN = 7'b0100000,
		ST_PDEXIT = 7'b1000000
	} crp_state_e;

	// what the core wants on the multiplexed address/data pins
	typedef struct packed {
		logic [`CRP_AD_W-1:0] addr;
		logic [`CRP_AD_W-1:0] data;
		logic addr_phase;
		logic data_write;
	} crp_core_bus_s;

	// a two-way pin group as seen from the design side
	typedef struct packed {
		logic [`CRP_AD_W-1:0] out;
		logic oe;
	} crp_ad_pin_s;
endpackage

/* File: src/crp_sync.sv */
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the inputs are levels that are stable for several clocks
`timescale 1ns/1ps
module crp_sync #(
	parameter int W = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_sync_out;

	// ****************************************
	// capture chain
	// ****************************************
	// first stage feeds only the second stage, never any logic
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

/* File: src/crp_clk_div.sv */
// half-rate clock generator with phase alignment on reset release
// assumes clk_sys is the doubled input clock and align_hold comes from a flop
`timescale 1ns/1ps
module crp_clk_div (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic align_hold,
	output logic half_rate_clock_out
);
	logic next_half;

	// ****************************************
	// divider
	// ****************************************
	// toggles on the falling edge; held low while aligning so phase restarts
	always_comb begin
		next_half = align_hold ? 1'b0 : ~half_rate_clock_out;
	end

	always_ff @(negedge clk_sys) begin
		if (!reset_n) begin
			half_rate_clock_out <= 1'b0;
		end else begin
			half_rate_clock_out <= next_half;
		end
	end

	property p_div_toggle;
		@(negedge clk_sys) disable iff (!reset_n)
		(!align_hold && !$past(align_hold)) |-> half_rate_clock_out != $past(half_rate_clock_out);
	endproperty
	a_div_toggle: assert property (p_div_toggle) else $error("half rate clock missed a toggle");
endmodule

/* File: tb/crp_board_model.sv */
// board-side partner: shared test/busy line and powerdown timer capacitor
// assumes it shares clk_sys with the block and that the bench picks the strap wiring
`timescale 1ns/1ps
module crp_board_model #(
	parameter int DISCH_CYC = 12
) (
	input wire logic clk_sys,
	input wire logic strap_reset_indication_out,
	input wire logic busy_level,
	input wire logic reset_indication_out,
	input wire logic timer_out,
	input wire logic timer_oe,
	output logic test_busy_pin,
	output logic powerdown_exit_timer_pin_in
);
	// ********
	// shared test/busy line
	// ********
	// reset indication wired to the pin selects coprocessor mode, busy comes after
	assign test_busy_pin = (strap_reset_indication_out & reset_indication_out) | busy_level;

	// ********
	// timer capacitor
	// ********
	// charges while driven high, then decays slowly so the exit is never instant
	int dis_cnt = DISCH_CYC;
	always @(posedge clk_sys) begin
		if (timer_oe && timer_out) begin
			dis_cnt <= 0;
		end else if (dis_cnt < DISCH_CYC) begin
			dis_cnt <= dis_cnt + 1;
		end
	end
	assign powerdown_exit_timer_pin_in = (dis_cnt < DISCH_CYC);
endmodule

/* File: tb/crp_pin_ctrl_tb.sv */
// self-checking bench for the clock, reset and pin-state control block
// assumes crp_regs.svh on the include path and the board model beside the block
`timescale 1ns/1ps
`include "crp_regs.svh"
module crp_pin_ctrl_tb;
	localparam int DISCH = 12;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic reset_input_n = 1'b0;
	logic nmi_pin = 1'b0, hold_ack = 1'b0, idle_req = 1'b0, powerdown_req = 1'b0;
	logic wake_event = 1'b0, wait_exec = 1'b0, nmi_ack = 1'b0;
	logic float_strap_ucs_n = 1'b1, float_strap_lcs_n = 1'b1;
	logic strap_reset_indication_out = 1'b0, busy_level = 1'b0;
	crp_pkg::crp_core_bus_s core_bus = '0;
	crp_pkg::crp_ad_pin_s ad_pins;
	logic test_busy_pin, tmr_in, tmr_out, tmr_oe, half_clk, xtal, xtal_oe, reset_ind;
	logic float_mode, coproc_mode, coproc_busy, cpu_stall, cpu_run, bus_abort;
	logic fetch_start, nmi_pending;
	logic [19:0] fetch_addr;
	logic [7:0] nmi_type;
	int n_mismatch = 0;
	int cmp_count = 0;

	// source at twice the operating rate, 100 MHz
	always #5 clk_sys = ~clk_sys;

	crp_pin_ctrl #(.PD_EXIT_MIN_CYC(4)) crp_pin_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.reset_input_n(reset_input_n), .nmi_pin(nmi_pin), .test_busy_pin(test_busy_pin),
		.float_strap_ucs_n(float_strap_ucs_n), .float_strap_lcs_n(float_strap_lcs_n),
		.hold_ack(hold_ack), .idle_req(idle_req), .powerdown_req(powerdown_req),
		.wake_event(wake_event), .wait_exec(wait_exec), .nmi_ack(nmi_ack),
		.core_bus(core_bus), .powerdown_exit_timer_pin_in(tmr_in),
		.half_rate_clock_out(half_clk), .crystal_drive_out(xtal), .crystal_drive_oe(xtal_oe),
		.reset_indication_out(reset_ind), .muxed_addr_data_bus(ad_pins),
		.powerdown_exit_timer_pin_out(tmr_out), .powerdown_exit_timer_pin_oe(tmr_oe),
		.all_pins_float_test_mode(float_mode), .coproc_mode(coproc_mode),
		.coproc_busy(coproc_busy), .cpu_stall(cpu_stall), .cpu_run(cpu_run),
		.bus_abort(bus_abort), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
		.nmi_pending(nmi_pending), .nmi_type(nmi_type));

	crp_board_model #(.DISCH_CYC(DISCH)) crp_board_model_i (.clk_sys(clk_sys),
		.strap_reset_indication_out(strap_reset_indication_out), .busy_level(busy_level), .reset_indication_out(reset_ind),
		.timer_out(tmr_out), .timer_oe(tmr_oe), .test_busy_pin(test_busy_pin),
		.powerdown_exit_timer_pin_in(tmr_in));

	// ********
	// compare and timing helpers
	// ********
	task automatic chk_bit(input string nm, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", nm, exp, got);
		end
	endtask

	task automatic chk_vec(input string nm, input logic [19:0] exp, input logic [19:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// lands 1 ns after the edge so registered outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// ********
	// scenarios
	// ********
	// reset entry with a bus cycle under way, then the release walk
	task automatic t_reset(input logic ucs_n, input logic lcs_n, input logic strap, input bit run);
		int i;
		@(posedge clk_sys);
		core_bus <= '{16'h5a5a, 16'h0, 1'b1, 1'b0};
		reset_input_n <= 1'b0;
		float_strap_ucs_n <= ucs_n;
		float_strap_lcs_n <= lcs_n;
		strap_reset_indication_out <= strap;
		tick(1);
		if (run) chk_bit("reset_ind_unsynced", 1'b0, reset_ind);
		tick(5);
		chk_bit("reset_ind", 1'b1, reset_ind);
		chk_bit("bus_abort", 1'b1, bus_abort);
		chk_bit("ad_oe_reset", 1'b0, ad_pins.oe);
		chk_bit("half_clk_reset", 1'b0, half_clk);
		chk_bit("cpu_run_reset", 1'b0, cpu_run);
		@(posedge clk_sys);
		reset_input_n <= 1'b1;
		for (i = 0; i < 12 && fetch_start !== 1'b1; i++) tick(1);
		chk_bit("fetch_start", 1'b1, fetch_start);
		chk_bit("fetch_late", 1'b1, i >= 2);
		chk_vec("fetch_addr", `CRP_FETCH_ADDR, fetch_addr);
		chk_bit("reset_ind_run", 1'b0, reset_ind);
		chk_bit("float_mode", ~(ucs_n | lcs_n), float_mode);
		chk_bit("coproc_mode", strap, coproc_mode);
		chk_bit("bus_abort_run", 1'b0, bus_abort);
		tick(1);
		chk_bit("fetch_pulse", 1'b0, fetch_start);
		@(posedge clk_sys);
		float_strap_ucs_n <= 1'b1;
		float_strap_lcs_n <= 1'b1;
	endtask

	task automatic t_clock;
		logic prev;
		tick(1);
		prev = half_clk;
		repeat (8) begin
			tick(1);
			chk_bit("half_clk", ~prev, half_clk);
			prev = half_clk;
		end
	endtask

	task automatic t_bus;
		@(posedge clk_sys);
		core_bus <= '{16'h1234, 16'hbeef, 1'b1, 1'b0};
		tick(2);
		chk_vec("ad_addr", 20'h01234, {4'h0, ad_pins.out});
		chk_bit("ad_oe_addr", 1'b1, ad_pins.oe);
		@(posedge clk_sys);
		core_bus <= '{16'h1234, 16'hbeef, 1'b0, 1'b1};
		tick(2);
		chk_vec("ad_data", 20'h0beef, {4'h0, ad_pins.out});
		@(posedge clk_sys);
		core_bus.data_write <= 1'b0;
		tick(2);
		chk_bit("ad_oe_read", 1'b0, ad_pins.oe);
	endtask

	task automatic t_hold;
		logic h0;
		@(posedge clk_sys);
		core_bus <= '{16'h00ff, 16'h0, 1'b1, 1'b0};
		hold_ack <= 1'b1;
		tick(3);
		chk_bit("ad_oe_hold", 1'b0, ad_pins.oe);
		chk_bit("reset_ind_hold", 1'b0, reset_ind);
		h0 = half_clk;
		tick(1);
		chk_bit("half_clk_hold", ~h0, half_clk);
		@(posedge clk_sys);
		hold_ack <= 1'b0;
		tick(3);
		chk_bit("ad_oe_unhold", 1'b1, ad_pins.oe);
	endtask

	task automatic t_nmi;
		int i;
		@(posedge clk_sys);
		nmi_pin <= 1'b1;
		for (i = 0; i < 8 && nmi_pending !== 1'b1; i++) tick(1);
		chk_bit("nmi_pending", 1'b1, nmi_pending);
		chk_vec("nmi_type", {12'h0, `CRP_NMI_TYPE}, {12'h0, nmi_type});
		@(posedge clk_sys);
		nmi_ack <= 1'b1;
		@(posedge clk_sys);
		nmi_ack <= 1'b0;
		tick(8);
		chk_bit("nmi_level_ignored", 1'b0, nmi_pending);
		@(posedge clk_sys);
		nmi_pin <= 1'b0;
	endtask

	// test pin high stalls the wait instruction, low lets it go
	task automatic t_wait;
		@(posedge clk_sys);
		busy_level <= 1'b1;
		wait_exec <= 1'b1;
		tick(4);
		chk_bit("stall_test_high", 1'b1, cpu_stall);
		@(posedge clk_sys);
		busy_level <= 1'b0;
		tick(4);
		chk_bit("stall_test_low", 1'b0, cpu_stall);
		@(posedge clk_sys);
		wait_exec <= 1'b0;
	endtask

	task automatic t_idle;
		@(posedge clk_sys);
		idle_req <= 1'b1;
		tick(3);
		chk_bit("ad_oe_idle", 1'b1, ad_pins.oe);
		chk_bit("reset_ind_idle", 1'b0, reset_ind);
		chk_bit("run_in_idle", 1'b0, cpu_run);
		@(posedge clk_sys);
		idle_req <= 1'b0;
		wake_event <= 1'b1;
		tick(3);
		chk_bit("run_after_idle", 1'b1, cpu_run);
		@(posedge clk_sys);
		wake_event <= 1'b0;
	endtask

	task automatic t_pdown;
		int n;
		@(posedge clk_sys);
		core_bus <= '{16'hc3c3, 16'h0, 1'b1, 1'b0};
		tick(2);
		@(posedge clk_sys);
		powerdown_req <= 1'b1;
		tick(3);
		@(posedge clk_sys);
		core_bus <= '{16'h0f0f, 16'h0, 1'b1, 1'b0};
		tick(3);
		chk_vec("ad_pdown_kept", 20'h0c3c3, {4'h0, ad_pins.out});
		chk_bit("reset_ind_pdown", 1'b0, reset_ind);
		chk_bit("tmr_drive_pdown", 1'b1, tmr_oe & tmr_out);
		@(posedge clk_sys);
		powerdown_req <= 1'b0;
		wake_event <= 1'b1;
		for (n = 0; n < 40 && cpu_run !== 1'b1; n++) tick(1);
		chk_bit("pd_exit_delay", 1'b1, n >= DISCH && n < DISCH + 12);
		@(posedge clk_sys);
		wake_event <= 1'b0;
	endtask

	task automatic t_float;
		logic px;
		t_reset(1'b0, 1'b0, 1'b0, 1'b1);
		tick(2);
		px = xtal;
		tick(1);
		chk_bit("xtal_float", ~px, xtal);
		chk_bit("ad_oe_float", 1'b0, ad_pins.oe);
		chk_bit("tmr_oe_float", 1'b0, tmr_oe);
		chk_bit("xtal_oe_float", 1'b1, xtal_oe);
	endtask

	task automatic t_coproc;
		t_reset(1'b1, 1'b1, 1'b1, 1'b1);
		@(posedge clk_sys);
		busy_level <= 1'b1;
		tick(4);
		chk_bit("coproc_busy", 1'b1, coproc_busy);
		@(posedge clk_sys);
		busy_level <= 1'b0;
		tick(4);
		chk_bit("coproc_idle", 1'b0, coproc_busy);
	endtask

	// ********
	// verdict and sequence
	// ********
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// the whole run needs well under 2000 cycles, so 20 us means a hang
	initial begin
		#20000;
		n_mismatch++;
		$display("Error watchdog expected done seen timeout");
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset(1'b1, 1'b1, 1'b0, 1'b0);
		t_clock();
		t_bus();
		t_hold();
		t_nmi();
		t_wait();
		t_idle();
		t_pdown();
		t_reset(1'b1, 1'b1, 1'b0, 1'b1);
		t_float();
		t_coproc();
		give_verdict();
	end
endmodule
